// ===== logic/chh_handshake_port.sv
// handler handshake port: trigger in, eoc/busy and judgments out
// assumes a classic wishbone master, and that the measuring core
// reports conversion and calculation completion as one-cycle pulses
// Behaviour
// R01: comparator mode drives bin on eleven outputs
// R02: qualified trigger pulse starts a measurement
// R03: eoc at conversion end, then calculate
// R04: busy marks measuring, calculating or comparing
// R05: selectable polarity for judgment and control outputs
// R06: handler holds trigger at least selected width
// R07: start delay at least fixed least delay
// R08: trigger accepted right after eoc
// R09: list bins one to ten flag point fails
// R10: bin zero flags any failed step
// R11: list judgments update only after sweep ends
// R12: sequential eoc after final step conversion
// R13: sequential busy done after all results valid
// R14: per-step eoc after each step conversion
// R15: per-step busy done after each step valid
// R16: handler uses results after final busy only
// R17: handler ignores data between eoc and busy
// R18: triggers during conversion are ignored
`timescale 1ns/1ps
`default_nettype none
`include "chh_map.svh"
module chh_handshake_port
  import chh_pkg::*;
#(
  parameter int CW = 16,
  parameter int DELAY_CYC = `CHH_MEAS_DELAY_CYC
) (
  input wire logic clk, // core clock
  input wire logic srst, // sync reset
  input wire logic [31:0] wb_adr_i, // wishbone address
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  output logic wb_ack_o, // wishbone acknowledge
  output logic wb_err_o, // wishbone error, unmapped address
  input wire logic trigIn, // trigger pin, asserted level from handler
  output logic convStart, // pulse: start analog conversion
  input wire logic convDone, // pulse: conversion finished
  input wire logic calcDone, // pulse: correction and compare done
  input wire logic [3:0] binResult, // bin number of the part
  input wire logic stepFail, // current step out of limit
  output logic [3:0] stepIndex, // sweep step being measured
  output logic [10:0] judgeOut, // judgment pins, selected level
  output logic eocOut, // end of conversion pin, selected level
  output logic busyOut // busy pin, selected level
);
  import chh_pkg::*;

  localparam int NP = `CHH_NUM_POINTS;
  localparam int NB = `CHH_NUM_BINS;

  logic [31:0] ctrlReg;
  logic [31:0] dispReg;
  chh_state_t stateReg;
  logic [CW-1:0] cntReg;
  logic eocReg;
  logic busyReg;
  logic [NB-1:0] judgeReg;
  logic [NP-1:0] failReg;
  logic trigValid;
  logic [CW-1:0] trigWidth;
  logic [CW-1:0] delayMax;
  chh_mode_t mode;
  logic [3:0] numPts;
  logic lastStep;
  logic busAcc;
  logic mapped;
  logic [31:0] rdData;
  logic pendReg;
  logic startOk;

  assign mode = chh_mode_t'(ctrlReg[`CHH_CTRL_MODE_LSB +: 2]);
  assign numPts = (ctrlReg[`CHH_CTRL_NPTS_LSB +: 4] == 4'h0 ||
    ctrlReg[`CHH_CTRL_NPTS_LSB +: 4] > 4'(NP)) ? 4'(NP)
    : ctrlReg[`CHH_CTRL_NPTS_LSB +: 4];
  assign lastStep = (stepIndex + 4'h1 >= numPts);
  assign trigWidth = ctrlReg[`CHH_CTRL_WSEL] ?
    CW'(`CHH_TRIG_LONG_CYC) : CW'(`CHH_TRIG_SHORT_CYC); // R06
  // display time extends the start window upper bound
  assign delayMax = CW'(DELAY_CYC) + dispReg[CW-1:0];
  // a start needs a resting state; calc only parks it
  assign startOk = (trigValid || pendReg) && (stateReg == CHH_IDLE ||
    stateReg == CHH_WAIT_TRIG || stateReg == CHH_DONE); // R08

  chh_trig_filter #(.W(CW)) uTrig (
    .clk(clk),
    .srst(srst),
    .trigPin(trigIn),
    .minWidth(trigWidth),
    .trigValid(trigValid)
  );

  // measurement sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      stateReg <= CHH_IDLE;
      cntReg <= '0;
      stepIndex <= 4'h0;
      convStart <= 1'b0;
    end else begin
      convStart <= 1'b0;
      unique case (stateReg)
        CHH_IDLE, CHH_WAIT_TRIG, CHH_DONE, CHH_CALC: begin
          // post-eoc trigger parked in calc starts here; R18 blocks CONVERT
          if (startOk) begin // R02 R08
            stateReg <= CHH_DELAY;
            cntReg <= '0;
            if (stateReg != CHH_WAIT_TRIG) begin
              stepIndex <= 4'h0;
            end
          end else if (stateReg == CHH_CALC && calcDone) begin
            if (mode == CHH_MODE_STEP && !lastStep) begin
              stateReg <= CHH_WAIT_TRIG;
              stepIndex <= stepIndex + 4'h1;
            end else if (mode == CHH_MODE_SEQ && !lastStep) begin
              stateReg <= CHH_CONVERT;
              stepIndex <= stepIndex + 4'h1;
              convStart <= 1'b1;
            end else begin
              stateReg <= CHH_DONE;
            end
          end
        end
        CHH_DELAY: begin
          cntReg <= cntReg + CW'(1);
          if (cntReg + CW'(1) >= CW'(DELAY_CYC)) begin // R07
            stateReg <= CHH_CONVERT;
            convStart <= 1'b1;
          end
        end
        CHH_CONVERT: begin
          if (convDone) begin // R18
            stateReg <= CHH_CALC;
          end
        end
      endcase
    end
  end

  // eoc: comparator every part, seq last step, step every step
  always_ff @(posedge clk) begin
    if (srst) begin
      eocReg <= 1'b0;
    end else if (stateReg == CHH_CONVERT && convDone) begin
      if (mode == CHH_MODE_SEQ) begin
        eocReg <= lastStep; // R12
      end else begin
        eocReg <= 1'b1; // R03 R14
      end
    end else if (stateReg == CHH_DELAY) begin
      eocReg <= 1'b0;
    end
  end

  // trigger qualified during calc after eoc, kept until the start it requests is taken
  always_ff @(posedge clk) begin
    if (srst) begin
      pendReg <= 1'b0;
    end else if (trigValid && stateReg == CHH_CALC && eocReg) begin
      pendReg <= 1'b1; // R08
    end else if (startOk) begin
      pendReg <= 1'b0;
    end
  end

  // busy high from trigger until data valid
  always_ff @(posedge clk) begin
    if (srst) begin
      busyReg <= 1'b0;
    end else if (startOk) begin
      busyReg <= 1'b1; // R04
    end else if (stateReg == CHH_CALC && calcDone) begin
      if (mode == CHH_MODE_SEQ) begin
        busyReg <= !lastStep; // R13
      end else begin
        busyReg <= 1'b0; // R04 R15
      end
    end
  end

  // per-point fail capture and judgment update
  always_ff @(posedge clk) begin
    if (srst) begin
      failReg <= '0;
      judgeReg <= '0;
    end else if (stateReg == CHH_CALC && calcDone) begin
      if (mode == CHH_MODE_COMPARE) begin
        for (int i = 0; i < NB; i++) begin
          judgeReg[i] <= (binResult == 4'(i)); // R01
        end
      end else if (lastStep) begin
        judgeReg[0] <= (|failReg) | stepFail; // R10 R11
        for (int i = 0; i < NP; i++) begin
          judgeReg[i+1] <= (4'(i) == stepIndex) ? stepFail
            : failReg[i]; // R09 R11
        end
        failReg <= '0;
      end else begin
        failReg[stepIndex] <= stepFail;
      end
    end
  end

  // output polarity, selected level per group
  always_ff @(posedge clk) begin
    if (srst) begin
      judgeOut <= '0;
      eocOut <= 1'b0;
      busyOut <= 1'b0;
    end else begin
      judgeOut <= judgeReg ^ {NB{ctrlReg[`CHH_CTRL_JPOL]}}; // R05
      eocOut <= eocReg ^ ctrlReg[`CHH_CTRL_CPOL]; // R05
      busyOut <= busyReg ^ ctrlReg[`CHH_CTRL_CPOL]; // R05
    end
  end

  // wishbone slave, one wait state
  assign busAcc = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  always_comb begin
    mapped = 1'b1;
    rdData = 32'h0000_0000;
    case (wb_adr_i)
      `CHH_REG_CTRL: rdData = ctrlReg;
      `CHH_REG_STATUS: rdData = {26'h0, stateReg} <<
        `CHH_STAT_STATE_LSB | {30'h0, busyReg, eocReg};
      `CHH_REG_RESULT: rdData = {21'h0, judgeReg};
      `CHH_REG_DISP: rdData = dispReg;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busAcc && mapped;
      wb_err_o <= busAcc && !mapped;
      wb_dat_o <= (busAcc && mapped && !wb_we_i) ? rdData : 32'h0000_0000;
    end
  end

  for (genvar b = 0; b < 4; b++) begin : gLane
    always_ff @(posedge clk) begin
      if (srst) begin
        ctrlReg[8*b +: 8] <= 8'(`CHH_CTRL_RESET >> (8*b));
        dispReg[8*b +: 8] <= 8'(`CHH_DISP_RESET >> (8*b));
      end else if (busAcc && wb_we_i && wb_sel_i[b]) begin
        if (wb_adr_i == `CHH_REG_CTRL) begin
          ctrlReg[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
        if (wb_adr_i == `CHH_REG_DISP) begin
          dispReg[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  a_start_delay: assert property (@(posedge clk) disable iff (srst) // R07
    $rose(convStart) && $past(stateReg) == CHH_DELAY |->
    $past(cntReg) + CW'(1) >= CW'(DELAY_CYC) && cntReg <= delayMax)
    else $error("start before least delay");
  a_ignore_conv: assert property (@(posedge clk) disable iff (srst) // R18
    stateReg == CHH_CONVERT && !convDone |=> stateReg == CHH_CONVERT)
    else $error("conversion left early");
  a_eoc_compare: assert property (@(posedge clk) disable iff (srst) // R03
    stateReg == CHH_CONVERT && convDone && mode != CHH_MODE_SEQ |=> eocReg)
    else $error("eoc missing after conversion");
  a_eoc_seq: assert property (@(posedge clk) disable iff (srst) // R12
    stateReg == CHH_CONVERT && convDone && mode == CHH_MODE_SEQ
    && !lastStep |=> !eocReg)
    else $error("seq eoc before last step");
  a_busy_seq: assert property (@(posedge clk) disable iff (srst) // R13
    stateReg == CHH_CALC && calcDone && mode == CHH_MODE_SEQ
    && !lastStep |=> busyReg)
    else $error("seq busy dropped early");
  a_busy_step: assert property (@(posedge clk) disable iff (srst) // R15
    stateReg == CHH_CALC && calcDone && mode == CHH_MODE_STEP
    |=> !busyReg)
    else $error("step busy not released");
  a_bin_onehot: assert property (@(posedge clk) disable iff (srst) // R01
    stateReg == CHH_CALC && calcDone && mode == CHH_MODE_COMPARE
    && binResult < 4'(NB) |=> $onehot(judgeReg))
    else $error("bin outputs not one-hot");
  a_overall_fail: assert property (@(posedge clk) disable iff (srst) // R10
    mode != CHH_MODE_COMPARE && $changed(judgeReg) |->
    judgeReg[0] == |judgeReg[NB-1:1])
    else $error("overall fail mismatch");
  a_polarity: assert property (@(posedge clk) disable iff (srst) // R05
    ##1 eocOut == ($past(eocReg) ^ $past(ctrlReg[`CHH_CTRL_CPOL])))
    else $error("eoc level wrong");
  a_pend_start: assert property (@(posedge clk) disable iff (srst) // R08
    pendReg && stateReg == CHH_DONE |=> stateReg == CHH_DELAY && busyReg)
    else $error("parked trigger not started");
  c_compare: cover property (@(posedge clk)
    mode == CHH_MODE_COMPARE && stateReg == CHH_CALC && calcDone);
  c_seq_done: cover property (@(posedge clk)
    mode == CHH_MODE_SEQ && $rose(stateReg == CHH_DONE));
  c_step_wait: cover property (@(posedge clk)
    mode == CHH_MODE_STEP && stateReg == CHH_WAIT_TRIG && trigValid);
  c_trig_eoc: cover property (@(posedge clk) eocReg && trigValid);
endmodule : chh_handshake_port
`default_nettype wire

// ===== logic/chh_map.svh
// constant map for the component handler handshake port
// assumes a 10 MHz core clock
`ifndef CHH_MAP_SVH
`define CHH_MAP_SVH
`define CHH_CLK_HZ 10000000
`define CHH_TRIG_SHORT_NS 5000
`define CHH_TRIG_LONG_NS 50000
`define CHH_MEAS_DELAY_NS 200000
`define CHH_NS_PER_S 1000000000
// least times round up to whole cycles
`define CHH_TRIG_SHORT_CYC ((`CHH_TRIG_SHORT_NS*(`CHH_CLK_HZ/1000000)+999)/1000)
`define CHH_TRIG_LONG_CYC ((`CHH_TRIG_LONG_NS*(`CHH_CLK_HZ/1000000)+999)/1000)
`define CHH_MEAS_DELAY_CYC ((`CHH_MEAS_DELAY_NS*(`CHH_CLK_HZ/1000000)+999)/1000)
`define CHH_NUM_POINTS 10
`define CHH_NUM_BINS 11
`define CHH_REG_CTRL 32'h0000_0000
`define CHH_REG_STATUS 32'h0000_0004
`define CHH_REG_RESULT 32'h0000_0008
`define CHH_REG_DISP 32'h0000_000C
`define CHH_CTRL_RESET 32'h0000_0000
`define CHH_DISP_RESET 32'h0000_0000
`define CHH_CTRL_MODE_LSB 0
`define CHH_CTRL_JPOL 2
`define CHH_CTRL_CPOL 3
`define CHH_CTRL_WSEL 4
`define CHH_CTRL_NPTS_LSB 8
`define CHH_STAT_EOC 0
`define CHH_STAT_BUSY 1
`define CHH_STAT_STATE_LSB 4
`endif

// ===== logic/chh_pkg.sv
// types for the component handler handshake port
// assumes chh_map.svh for numbers
package chh_pkg;
  typedef enum logic [1:0] {
    CHH_MODE_COMPARE = 2'h0,
    CHH_MODE_SEQ = 2'h1,
    CHH_MODE_STEP = 2'h2
  } chh_mode_t;
  typedef enum logic [5:0] {
    CHH_IDLE = 6'h01,
    CHH_DELAY = 6'h02,
    CHH_CONVERT = 6'h04,
    CHH_CALC = 6'h08,
    CHH_WAIT_TRIG = 6'h10,
    CHH_DONE = 6'h20
  } chh_state_t;
endpackage : chh_pkg

// ===== logic/chh_trig_filter.sv
// trigger input synchroniser and pulse width qualifier
// assumes an asynchronous trigger pin from the handler
`timescale 1ns/1ps
`default_nettype none
`include "chh_map.svh"
module chh_trig_filter #(
  parameter int W = 10
) (
  input wire logic clk, // core clock
  input wire logic srst, // sync reset
  input wire logic trigPin, // raw trigger pin, asserted level
  input wire logic [W-1:0] minWidth, // least width in cycles
  output logic trigValid // one cycle once width met
);
  logic sync1Reg;
  logic sync2Reg;
  logic [W-1:0] cntReg;
  logic firedReg;

  always_ff @(posedge clk) begin
    if (srst) begin
      sync1Reg <= 1'b0;
      sync2Reg <= 1'b0;
    end else begin
      sync1Reg <= trigPin;
      sync2Reg <= sync1Reg;
    end
  end

  // width count; fires once per pulse
  always_ff @(posedge clk) begin
    if (srst || !sync2Reg) begin
      cntReg <= '0;
      firedReg <= 1'b0;
      trigValid <= 1'b0;
    end else begin
      trigValid <= 1'b0;
      if (!firedReg) begin
        if (cntReg + W'(1) >= minWidth) begin
          firedReg <= 1'b1;
          trigValid <= 1'b1; // R02
        end else begin
          cntReg <= cntReg + W'(1);
        end
      end
    end
  end
endmodule : chh_trig_filter
`default_nettype wire

// ===== tb/chh_handler_model.sv
// handler model: trigger pulses, judgments read at busy end
// assumes the bench commands it on the port clock
`timescale 1ns/1ps
`default_nettype none
module chh_handler_model (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic fire, // request a pulse
  input wire logic longWidth, // long width set
  input wire logic busyIdle, // busy pin idle
  input wire logic [10:0] judgeOut, // judgment pins
  output logic trigIn, // trigger pin
  output logic [10:0] judgeTaken // judgments read
);
  logic [9:0] holdCnt;
  logic idleReg;
  // pulse kept a margin above the least width
  always_ff @(posedge clk) begin
    if (srst) begin
      holdCnt <= 10'h000;
    end else if (fire) begin
      holdCnt <= longWidth ? 10'h208 : 10'h03C;
    end else if (holdCnt != 10'h000) begin
      holdCnt <= holdCnt - 10'h001;
    end
  end
  assign trigIn = (holdCnt != 10'h000);
  // results only trusted once busy has ended
  always_ff @(posedge clk) begin
    idleReg <= busyIdle;
    if (srst) begin
      judgeTaken <= 11'h000;
    end else if (busyIdle && !idleReg) begin
      judgeTaken <= judgeOut;
    end
  end
endmodule : chh_handler_model
`default_nettype wire

// ===== tb/tb_component_handler_handshake_port.sv
// bench for the handler handshake port
// assumes the handler model; bench plays the measuring core
`timescale 1ns/1ps
`default_nettype none
`include "chh_map.svh"
module tb_component_handler_handshake_port;
  import chh_pkg::*;
  localparam int DLY = 20;
  logic clk, srst, wbWe, wbCyc, wbStb, wbAck, wbErr, trigIn, convStart;
  logic convDone, calcDone, stepFail, eocOut, busyOut, fire, longW;
  logic jpol, cpol;
  logic [31:0] wbAdr, wbDatW, wbDatR;
  logic [3:0] wbSel, binResult, stepIdx;
  logic [10:0] judgeOut, judgeTaken, expJ;
  chh_mode_t mode;
  int failCount, nChecks;
  chh_handshake_port #(.DELAY_CYC(DLY)) u_dut (.clk(clk), .srst(srst),
    .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_we_i(wbWe),
    .wb_sel_i(wbSel), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_ack_o(wbAck),
    .wb_err_o(wbErr), .trigIn(trigIn), .convStart(convStart),
    .convDone(convDone), .calcDone(calcDone), .binResult(binResult),
    .stepFail(stepFail), .stepIndex(stepIdx), .judgeOut(judgeOut),
    .eocOut(eocOut), .busyOut(busyOut));
  chh_handler_model u_handler (.clk(clk), .srst(srst), .fire(fire),
    .longWidth(longW), .busyIdle(busyOut === cpol), .judgeOut(judgeOut),
    .trigIn(trigIn), .judgeTaken(judgeTaken));
  task automatic finalReport();
    if (failCount == 0 && nChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finalReport
  task automatic chk(input string what, input logic [31:0] exp, got);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic waitLvl(ref logic s, input logic lvl, output int n);
    n = 0;
    while (s !== lvl) begin
      if (n == 3000) begin
        failCount++;
        finalReport();
      end
      tick(1);
      n++;
    end
  endtask : waitLvl
  task automatic wbAcc(input logic we, input logic [31:0] adr, dat,
                       output logic [31:0] rd, output logic er);
    int n;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= dat;
    wbSel <= 4'hF;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 50);
    if (n == 50) begin
      failCount++;
      finalReport();
    end
    rd = wbDatR;
    er = wbErr;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    tick(1);
  endtask : wbAcc
  task automatic setCtrl(input chh_mode_t m, input logic jp, cp, w,
                         input logic [3:0] np);
    logic [31:0] rd;
    logic er;
    wbAcc(1'b1, `CHH_REG_CTRL, {20'h0, np, 3'h0, w, cp, jp, m}, rd, er);
    mode <= m;
    jpol <= jp;
    cpol <= cp;
    longW <= w;
    tick(2);
  endtask : setCtrl
  task automatic fireTrig();
    fire <= 1'b1;
    tick(1);
    fire <= 1'b0;
  endtask : fireTrig
  task automatic convEnd();
    tick(3);
    convDone <= 1'b1;
    tick(1);
    convDone <= 1'b0;
    tick(3);
  endtask : convEnd
  task automatic calcEnd(input logic [3:0] bin, input logic f);
    binResult <= bin;
    stepFail <= f;
    calcDone <= 1'b1;
    tick(1);
    calcDone <= 1'b0;
  endtask : calcEnd
  // one part or sweep, core answers each conversion
  task automatic run(input logic [3:0] bin, input logic [9:0] fails,
                     input int np, input logic trigEach, doFire);
    int n, k;
    logic last;
    for (k = 0; k < np; k++) begin
      last = (k == np - 1);
      if (k == 0 ? doFire : trigEach) begin
        fireTrig();
        waitLvl(busyOut, ~cpol, n);
        waitLvl(convStart, 1'b1, n);
        chk("delay", 32'(n >= DLY - 2 && n <= DLY), 32'h1);
      end else begin
        waitLvl(convStart, 1'b1, n);
      end
      convEnd();
      chk("step", 32'(k), 32'(stepIdx));
      chk("eoc", 32'(eocOut ^ cpol), 32'(mode != CHH_MODE_SEQ || last));
      chk("busy", 32'(busyOut ^ cpol), 32'h1);
      chk("judge held", 32'(judgeOut ^ {11{jpol}}), 32'(expJ));
      if (mode == CHH_MODE_COMPARE) begin
        expJ = 11'h001 << bin;
      end else if (last) begin
        expJ = {fails, |fails};
      end
      calcEnd(bin, fails[k]);
      if (mode != CHH_MODE_SEQ || last) begin
        tick(3);
        chk("busy end", 32'(busyOut ^ cpol), 32'h0);
        chk("judge", 32'(judgeOut ^ {11{jpol}}), 32'(expJ));
      end
    end
  endtask : run
  task automatic scReset();
    logic [31:0] rd;
    logic er;
    chk("idle pins", {19'h0, eocOut, busyOut, judgeOut}, 32'h0);
    wbAcc(1'b0, `CHH_REG_CTRL, 32'h0, rd, er);
    chk("ctrl", `CHH_CTRL_RESET, rd);
    wbAcc(1'b1, `CHH_REG_DISP, 32'h0000_0040, rd, er);
    wbAcc(1'b0, `CHH_REG_DISP, 32'h0000_0000, rd, er);
    chk("disp", 32'h0000_0040, rd);
    wbAcc(1'b0, 32'h0000_0010, 32'h0, rd, er);
    chk("unmapped", 32'(er), 32'h1);
  endtask : scReset
  task automatic scPolarity();
    setCtrl(CHH_MODE_COMPARE, 1'b1, 1'b1, 1'b0, 4'h0);
    chk("inv pins", {19'h0, eocOut, busyOut, judgeOut}, 32'h1FFF);
    run(4'h5, 10'h000, 1, 1'b0, 1'b1);
  endtask : scPolarity
  task automatic scBins();
    int b;
    setCtrl(CHH_MODE_COMPARE, 1'b0, 1'b0, 1'b0, 4'h0);
    for (b = 0; b <= 10; b++) begin
      run(4'(b), 10'h000, 1, 1'b0, 1'b1);
    end
  endtask : scBins
  task automatic scList();
    setCtrl(CHH_MODE_SEQ, 1'b0, 1'b0, 1'b0, 4'h3);
    run(4'h0, 10'h005, 3, 1'b0, 1'b1);
    chk("seq taken", 32'(judgeTaken), 32'h00B);
    setCtrl(CHH_MODE_STEP, 1'b0, 1'b0, 1'b1, 4'h2);
    run(4'h0, 10'h002, 2, 1'b1, 1'b1);
    chk("step taken", 32'(judgeTaken), 32'h005);
  endtask : scList
  task automatic scRefuse();
    int n;
    setCtrl(CHH_MODE_COMPARE, 1'b0, 1'b0, 1'b0, 4'h0);
    fireTrig();
    waitLvl(convStart, 1'b1, n);
    fireTrig();
    tick(80);
    convEnd();
    calcEnd(4'h3, 1'b0);
    n = 0;
    repeat (DLY + 120) begin
      tick(1);
      if (convStart !== 1'b0) n++;
    end
    chk("ignored trig", 32'(n), 32'h0);
    expJ = 11'h008;
    chk("judge", 32'(judgeOut), 32'(expJ));
    fireTrig();
    waitLvl(convStart, 1'b1, n);
    convEnd();
    fireTrig();
    tick(60);
    calcEnd(4'h7, 1'b0);
    expJ = 11'h080;
    run(4'h2, 10'h000, 1, 1'b0, 1'b0);
  endtask : scRefuse
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {srst, wbWe, wbCyc, wbStb, convDone, calcDone, stepFail, fire} = 8'h80;
    {longW, jpol, cpol} = 3'h0;
    {wbAdr, wbDatW} = 64'h0;
    wbSel = 4'h0;
    binResult = 4'h0;
    expJ = 11'h000;
    mode = CHH_MODE_COMPARE;
    failCount = 0;
    nChecks = 0;
    tick(6);
    srst <= 1'b0;
    tick(1);
    scReset();
    scPolarity();
    scBins();
    scList();
    scRefuse();
    finalReport();
  end
endmodule : tb_component_handler_handshake_port
`default_nettype wire
